/* src/bcm_match.sv */
// break channel match: channel c data/cycle/count and channel d address
//
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps

// Overview of operation
// RULE_01: a clear data mask bit compares that data bit; a set bit ignores it.
// RULE_02: with x/y enabled, upper mask half masks x data, lower half y data.
// RULE_03: both data mask halves clear to zero at power-on reset.
// RULE_04: software places byte compare values in the lane of the address.
// RULE_05: software also programs an operand size when data is compared.
// RULE_06: cycle condition bits 15 to 10 read zero; software writes zero.
// RULE_07: cycle bit 9 picks internal bus or x/y buses for address and data; here only channel c data, channel d address uses control bit 1.
// RULE_08: cycle bit 8 picks x or y bus, only while x/y enable is set.
// RULE_09: cycle bits 7 to 0 select cpu/dma, fetch/data, read/write, size.
// RULE_10: cycle condition register clears to zero at power-on reset.
// RULE_11: with count break enabled, each channel c hit decrements the count.
// RULE_12: a hit while the count is one raises the break request.
// RULE_13: count is 12 bits; bits 15 to 12 read zero, software writes zero.
// RULE_14: hits inside short repeat loops never decrement the count.
// RULE_15: count register clears to zero at power-on reset.
// RULE_16: channel d address compares full address, or x and y halves.
// RULE_17: both channel d address halves clear to zero at power-on reset.
// RULE_18: with x/y enabled, upper data half compares x data, lower y data.
// RULE_19: address bit zero of the x and y buses is never compared.
// RULE_20: a hit needs data, address and all selected attributes matching together; channel c here matches data and attributes, channel d address only.
module bcm_match #(
    parameter int ADDR_WIDTH = 8
) (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst_b,
    // apb slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [ADDR_WIDTH-1:0] paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // internal bus cycle
    input  wire logic                  busValid,
    input  wire logic [31:0]           busAddr,
    input  wire logic [31:0]           busData,
    // attributes of the current cycle on any bus
    input  wire logic                  cycIsDma,
    input  wire logic                  cycIsData,
    input  wire logic                  cycIsWrite,
    input  wire logic [1:0]            cycSize,
    input  wire logic                  cycInShortRepeat,
    // x and y memory buses
    input  wire logic                  xValid,
    input  wire logic [15:0]           xAddr,
    input  wire logic [15:0]           xData,
    input  wire logic                  yValid,
    input  wire logic [15:0]           yAddr,
    input  wire logic [15:0]           yData,
    // break results
    output logic                       breakReq,
    output logic                       chanCHit,
    output logic                       chanDHit
);

    if (ADDR_WIDTH < 6 || ADDR_WIDTH > 32) begin : gBadWidth
        $error("bcm_match: ADDR_WIDTH must be 6 to 32");
    end

    default clocking assertClk @(posedge clk); endclocking
    default disable iff (!rst_b);

    ////////////////////////////////////////////////////////////////////////
    // register state

    logic [15:0] maskHi_q;
    logic [15:0] maskLo_q;
    logic [15:0] cycle_q;
    logic [11:0] count_q;
    logic [11:0] count_d;
    logic [15:0] dAddrHi_q;
    logic [15:0] dAddrLo_q;
    logic [15:0] dataHi_q;
    logic [15:0] dataLo_q;
    logic [2:0]  control_q;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic        pready_q;
    logic        pslverr_q;
    logic        breakReq_q;
    logic        breakReq_d;
    logic        chanCHit_q;
    logic        chanDHit_q;

    ////////////////////////////////////////////////////////////////////////
    // apb decode

    wire [7:0] regAddr   = 8'(paddr);
    wire       upperZero = (paddr >> 8) == '0;
    wire       setupCyc  = psel & ~penable;
    wire       accessEnd = psel & penable & pready_q;
    wire       wrEn      = accessEnd & pwrite;
    wire       selMaskHi = upperZero && regAddr == bcm_pkg::OFF_C_MASK_HI;
    wire       selMaskLo = upperZero && regAddr == bcm_pkg::OFF_C_MASK_LO;
    wire       selCycle  = upperZero && regAddr == bcm_pkg::OFF_C_CYCLE;
    wire       selCount  = upperZero && regAddr == bcm_pkg::OFF_C_COUNT;
    wire       selDHi    = upperZero && regAddr == bcm_pkg::OFF_D_ADDR_HI;
    wire       selDLo    = upperZero && regAddr == bcm_pkg::OFF_D_ADDR_LO;
    wire       selDataHi = upperZero && regAddr == bcm_pkg::OFF_C_DATA_HI;
    wire       selDataLo = upperZero && regAddr == bcm_pkg::OFF_C_DATA_LO;
    wire       selCtrl   = upperZero && regAddr == bcm_pkg::OFF_CONTROL;
    wire       mapped    = selMaskHi | selMaskLo | selCycle | selCount | selDHi
                         | selDLo | selDataHi | selDataLo | selCtrl;
    wire       wrCount   = wrEn & selCount;

    // reserved bits return zero through zero extension
    always_comb begin
        prdata_d = 32'h00000000;
        if (selMaskHi) prdata_d = {16'h0000, maskHi_q};
        if (selMaskLo) prdata_d = {16'h0000, maskLo_q};
        if (selCycle)  prdata_d = {16'h0000, cycle_q};
        if (selCount)  prdata_d = {20'h00000, count_q};
        if (selDHi)    prdata_d = {16'h0000, dAddrHi_q};
        if (selDLo)    prdata_d = {16'h0000, dAddrLo_q};
        if (selDataHi) prdata_d = {16'h0000, dataHi_q};
        if (selDataLo) prdata_d = {16'h0000, dataLo_q};
        if (selCtrl)   prdata_d = {29'h00000000, control_q};
    end

    // one wait-free access cycle: answer registered in setup
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h00000000;
        end else begin
            pready_q  <= setupCyc;
            pslverr_q <= setupCyc & ~mapped;
            prdata_q  <= (setupCyc & ~pwrite) ? prdata_d : 32'h00000000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // configuration registers

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            maskHi_q  <= bcm_pkg::RST_HALF; // see RULE_03
            maskLo_q  <= bcm_pkg::RST_HALF; // see RULE_03
            cycle_q   <= bcm_pkg::RST_HALF; // see RULE_10
            dAddrHi_q <= bcm_pkg::RST_HALF; // see RULE_17
            dAddrLo_q <= bcm_pkg::RST_HALF; // see RULE_17
            dataHi_q  <= bcm_pkg::RST_HALF;
            dataLo_q  <= bcm_pkg::RST_HALF;
            control_q <= bcm_pkg::RST_CONTROL;
        end else if (wrEn) begin
            if (selMaskHi) maskHi_q <= pwdata[15:0];
            if (selMaskLo) maskLo_q <= pwdata[15:0];
            if (selCycle)  cycle_q <= pwdata[15:0] & bcm_pkg::CYCLE_WR_MASK; // see RULE_06
            if (selDHi)    dAddrHi_q <= pwdata[15:0];
            if (selDLo)    dAddrLo_q <= pwdata[15:0];
            if (selDataHi) dataHi_q <= pwdata[15:0];
            if (selDataLo) dataLo_q <= pwdata[15:0];
            if (selCtrl)   control_q <= pwdata[2:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // channel c cycle attributes

    wire       xyEnC    = cycle_q[bcm_pkg::POS_XY_EN];  // see RULE_07
    wire       xySelC   = cycle_q[bcm_pkg::POS_XY_SEL]; // see RULE_08
    wire [1:0] selCpu   = cycle_q[bcm_pkg::POS_CPU_DMA+:2];
    wire [1:0] selFetch = cycle_q[bcm_pkg::POS_FETCH_ACC+:2];
    wire [1:0] selDir   = cycle_q[bcm_pkg::POS_DIR+:2];
    wire [1:0] selSize  = cycle_q[bcm_pkg::POS_SIZE+:2];

    // first code wants the attribute low, second wants it high
    function automatic logic fieldOk(input logic [1:0] sel, input logic attr);
        fieldOk = (sel == bcm_pkg::SEL_FIRST)  ? ~attr :
                  (sel == bcm_pkg::SEL_SECOND) ? attr  : 1'b1;
    endfunction : fieldOk

    wire cpuOk  = fieldOk(selCpu, cycIsDma);     // see RULE_09
    wire fetchOk = fieldOk(selFetch, cycIsData); // see RULE_09
    wire dirOk  = fieldOk(selDir, cycIsWrite);   // see RULE_09
    wire sizeOk = selSize == bcm_pkg::SIZE_ANY || selSize == cycSize; // see RULE_09
    wire attrOk = cpuOk & fetchOk & dirOk & sizeOk;

    ////////////////////////////////////////////////////////////////////////
    // channel c data compare

    wire [31:0] careC   = ~{maskHi_q, maskLo_q};                    // see RULE_01
    wire [31:0] diffBus = (busData ^ {dataHi_q, dataLo_q}) & careC; // see RULE_01
    wire [15:0] diffX   = (xData ^ dataHi_q) & careC[31:16];        // see RULE_02, RULE_18
    wire [15:0] diffY   = (yData ^ dataLo_q) & careC[15:0];         // see RULE_02, RULE_18
    wire        dataBusOk = busValid & (diffBus == 32'h00000000);
    wire        dataXOk   = xValid & (diffX == 16'h0000);
    wire        dataYOk   = yValid & (diffY == 16'h0000);
    wire        dataOkC   = ~xyEnC ? dataBusOk : (xySelC ? dataYOk : dataXOk); // see RULE_07, RULE_08
    wire        hitC      = dataOkC & attrOk; // see RULE_20

    ////////////////////////////////////////////////////////////////////////
    // channel d address compare

    wire xyEnD  = control_q[bcm_pkg::POS_D_XY_EN];
    wire xySelD = control_q[bcm_pkg::POS_D_XY_SEL];
    wire addrBusOk = busValid & (busAddr == {dAddrHi_q, dAddrLo_q});        // see RULE_16
    wire addrXOk   = xValid & (xAddr[15:1] == dAddrHi_q[15:1]);             // see RULE_16, RULE_19
    wire addrYOk   = yValid & (yAddr[15:1] == dAddrLo_q[15:1]);             // see RULE_16, RULE_19
    wire hitD      = ~xyEnD ? addrBusOk : (xySelD ? addrYOk : addrXOk);    // see RULE_20

    ////////////////////////////////////////////////////////////////////////
    // execution countdown and break request

    wire cntEn    = control_q[bcm_pkg::POS_CNT_EN];
    wire hitCount = hitC & ~cycInShortRepeat;         // see RULE_14
    wire atLast   = count_q <= bcm_pkg::COUNT_LAST;
    wire reqC     = hitCount & (~cntEn | atLast);     // see RULE_12

    // a software write to the count wins over a same-cycle decrement
    always_comb begin
        count_d = count_q;
        if (wrCount) begin
            count_d = pwdata[11:0] & bcm_pkg::COUNT_WR_MASK[11:0]; // see RULE_13
        end else if (cntEn & hitCount & count_q != 12'h000) begin
            count_d = count_q - 12'h001; // see RULE_11
        end
    end

    assign breakReq_d = reqC | hitD;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count_q    <= bcm_pkg::RST_COUNT; // see RULE_15
            breakReq_q <= 1'b0;
            chanCHit_q <= 1'b0;
            chanDHit_q <= 1'b0;
        end else begin
            count_q    <= count_d;
            breakReq_q <= breakReq_d;
            chanCHit_q <= hitC;
            chanDHit_q <= hitD;
        end
    end

    assign prdata   = prdata_q;
    assign pready   = pready_q;
    assign pslverr  = pslverr_q;
    assign breakReq = breakReq_q;
    assign chanCHit = chanCHit_q;
    assign chanDHit = chanDHit_q;

    ////////////////////////////////////////////////////////////////////////
    // checks

    mask_compare_a : assert property ( // see RULE_01
        @(posedge clk) disable iff (!rst_b)
        (!xyEnC && busValid && ((busData ^ {dataHi_q, dataLo_q}) & ~{maskHi_q, maskLo_q}) != 32'h0)
        |=> !chanCHit_q)
        else $error("unmasked data mismatch still hit");

    xy_data_a : assert property ( // see RULE_18
        @(posedge clk) disable iff (!rst_b)
        (xyEnC && !xySelC && xValid && attrOk && ((xData ^ dataHi_q) & ~maskHi_q) == 16'h0)
        |=> chanCHit_q)
        else $error("x data match missed");

    size_attr_a : assert property ( // see RULE_09
        @(posedge clk) disable iff (!rst_b)
        (selSize != 2'h0 && cycSize != selSize) |=> !chanCHit_q)
        else $error("size mismatch still hit");

    reset_zero_a : assert property ( // see RULE_03
        @(posedge clk) $rose(rst_b) |-> maskHi_q == 16'h0 && maskLo_q == 16'h0
            && cycle_q == 16'h0 && count_q == 12'h0 && dAddrHi_q == 16'h0)
        else $error("register not cleared by reset");

    cycle_rsvd_a : assert property ( // see RULE_06
        @(posedge clk) disable iff (!rst_b)
        (setupCyc && !pwrite && selCycle) |=> prdata_q[15:10] == 6'h0)
        else $error("cycle reserved bits read nonzero");

    count_rsvd_a : assert property ( // see RULE_13
        @(posedge clk) disable iff (!rst_b)
        (setupCyc && !pwrite && selCount) |=> prdata_q[31:12] == 20'h0)
        else $error("count upper bits read nonzero");

    count_dec_a : assert property ( // see RULE_11
        @(posedge clk) disable iff (!rst_b)
        (cntEn && hitC && !cycInShortRepeat && !wrCount && count_q > 12'h1)
        |=> count_q == $past(count_q) - 12'h1 && !breakReq_q || chanDHit_q)
        else $error("count not decremented");

    count_req_a : assert property ( // see RULE_12
        @(posedge clk) disable iff (!rst_b)
        (cntEn && hitC && !cycInShortRepeat && !wrCount && count_q == 12'h1) |=> breakReq_q ##0 count_q == 12'h0)
        else $error("no request on last count");

    repeat_hold_a : assert property ( // see RULE_14
        @(posedge clk) disable iff (!rst_b)
        (hitC && cycInShortRepeat && !wrCount) |=> $stable(count_q))
        else $error("count moved inside short repeat");

    xy_addr_a : assert property ( // see RULE_19
        @(posedge clk) disable iff (!rst_b)
        (xyEnD && !xySelD && xValid && xAddr[15:1] == dAddrHi_q[15:1]) |=> chanDHit_q && breakReq_q)
        else $error("x address match missed");

    y_data_a : assert property ( // see RULE_18
        (xyEnC && xySelC && yValid && attrOk && ((yData ^ dataLo_q) & ~maskLo_q) == 16'h0)
        |=> chanCHit_q)
        else $error("y data match missed");

    x_mask_a : assert property ( // see RULE_02
        (xyEnC && !xySelC && ((xData ^ dataHi_q) & ~maskHi_q) != 16'h0)
        |=> !chanCHit_q)
        else $error("x data mismatch still hit");

    bus_select_a : assert property ( // see RULE_07
        (xyEnC && !xValid && !yValid)
        |=> !chanCHit_q)
        else $error("internal bus hit with x/y on");

    dir_attr_a : assert property ( // see RULE_09
        (selDir == bcm_pkg::SEL_FIRST && cycIsWrite)
        |=> !chanCHit_q)
        else $error("write hit a read condition");

    dma_attr_a : assert property ( // see RULE_09
        (selCpu == bcm_pkg::SEL_SECOND && !cycIsDma)
        |=> !chanCHit_q)
        else $error("cpu cycle hit a dma condition");

    no_count_req_a : assert property ( // see RULE_20
        (!cntEn && hitC && !cycInShortRepeat)
        |=> breakReq_q)
        else $error("hit without request");

    repeat_req_a : assert property ( // see RULE_14
        (hitC && cycInShortRepeat && !hitD)
        |=> !breakReq_q)
        else $error("request inside short repeat");

    zero_count_a : assert property ( // see RULE_12
        (cntEn && hitC && !cycInShortRepeat && !wrCount && count_q == 12'h0)
        |=> breakReq_q && count_q == 12'h0)
        else $error("no request at zero count");

    d_addr_a : assert property ( // see RULE_16
        (!xyEnD && busValid && busAddr == {dAddrHi_q, dAddrLo_q})
        |=> chanDHit_q && breakReq_q)
        else $error("full address match missed");

    y_addr_a : assert property ( // see RULE_19
        (xyEnD && xySelD && yValid && yAddr[15:1] == dAddrLo_q[15:1])
        |=> chanDHit_q)
        else $error("y address match missed");

    d_reset_a : assert property ( // see RULE_17
        $rose(rst_b)
        |-> dAddrHi_q == 16'h0 && dAddrLo_q == 16'h0)
        else $error("channel d address not cleared");

    count_write_a : assert property ( // see RULE_13
        wrCount
        |=> count_q == $past(pwdata[11:0]))
        else $error("count write lost");

    cycle_write_a : assert property ( // see RULE_06
        (wrEn && selCycle)
        |=> cycle_q == ($past(pwdata[15:0]) & 16'h03FF))
        else $error("cycle write not masked");

    count_hold_a : assert property ( // see RULE_11
        (!cntEn && !wrCount)
        |=> $stable(count_q))
        else $error("count moved while disabled");

endmodule : bcm_match

/* common/bcm_pkg.sv */
// constants for the break channel match block
package bcm_pkg;

    // register byte offsets
    localparam logic [7:0] OFF_C_MASK_HI  = 8'h00;
    localparam logic [7:0] OFF_C_MASK_LO  = 8'h04;
    localparam logic [7:0] OFF_C_CYCLE    = 8'h08;
    localparam logic [7:0] OFF_C_COUNT    = 8'h0C;
    localparam logic [7:0] OFF_D_ADDR_HI  = 8'h10;
    localparam logic [7:0] OFF_D_ADDR_LO  = 8'h14;
    localparam logic [7:0] OFF_C_DATA_HI  = 8'h18;
    localparam logic [7:0] OFF_C_DATA_LO  = 8'h1C;
    localparam logic [7:0] OFF_CONTROL    = 8'h20;

    // reset values
    localparam logic [15:0] RST_HALF      = 16'h0000;
    localparam logic [11:0] RST_COUNT     = 12'h000;
    localparam logic [2:0]  RST_CONTROL   = 3'h0;

    // cycle condition fields
    localparam int          POS_XY_EN     = 9;
    localparam int          POS_XY_SEL    = 8;
    localparam int          POS_CPU_DMA   = 6;
    localparam int          POS_FETCH_ACC = 4;
    localparam int          POS_DIR       = 2;
    localparam int          POS_SIZE      = 0;
    localparam logic [15:0] CYCLE_WR_MASK = 16'h03FF;
    localparam logic [15:0] COUNT_WR_MASK = 16'h0FFF;

    // control register bits
    localparam int          POS_CNT_EN    = 0;
    localparam int          POS_D_XY_EN   = 1;
    localparam int          POS_D_XY_SEL  = 2;

    // two-bit selector encodings
    localparam logic [1:0]  SEL_FIRST     = 2'h1;
    localparam logic [1:0]  SEL_SECOND    = 2'h2;
    localparam logic [1:0]  SIZE_ANY      = 2'h0;

    // countdown value at which the next hit requests a break
    localparam logic [11:0] COUNT_LAST    = 12'h001;

endpackage : bcm_pkg

/* verification/bcm_bus_model.sv */
// cpu and dma bus model that feeds cycles into the match block
`timescale 1ns/10ps
module bcm_bus_model (
    // clock
    input  wire logic clk,
    // internal bus
    output logic        busValid,
    output logic [31:0] busAddr,
    output logic [31:0] busData,
    // cycle attributes
    output logic        cycIsDma,
    output logic        cycIsData,
    output logic        cycIsWrite,
    output logic [1:0]  cycSize,
    output logic        cycInShortRepeat,
    // x and y memory buses
    output logic        xValid,
    output logic [15:0] xAddr,
    output logic [15:0] xData,
    output logic        yValid,
    output logic [15:0] yAddr,
    output logic [15:0] yData
);
    initial begin
        {busValid, xValid, yValid} = 3'h0;
        {busAddr, busData, xAddr, yAddr, xData, yData} = 128'h0;
        {cycIsDma, cycIsData, cycIsWrite, cycSize, cycInShortRepeat} = 6'h3F;
    end

    // one cycle on the internal bus or on the x or y bus, then release
    task automatic cycle(input logic onXy, input logic ySel, input logic [31:0] a, input logic [31:0] d,
                         input logic [5:0] attr);
        @(posedge clk);
        busValid <= !onXy;
        xValid <= onXy && !ySel;
        yValid <= onXy && ySel;
        {busAddr, busData} <= {a, d};
        {xAddr, yAddr, xData, yData} <= {a, d};
        {cycIsDma, cycIsData, cycIsWrite, cycSize, cycInShortRepeat} <= attr;
        @(posedge clk);
        {busValid, xValid, yValid} <= 3'h0;
        // released lines show the inverse so a stale value can never match
        {busAddr, busData} <= ~{a, d};
        {xAddr, yAddr, xData, yData} <= ~{a, d};
        {cycIsDma, cycIsData, cycIsWrite, cycSize, cycInShortRepeat} <= ~attr;
    endtask : cycle
endmodule : bcm_bus_model

/* verification/bcm_match_test.sv */
// self-checking bench for the break channel match block
`timescale 1ns/10ps
module bcm_match_test;
    localparam logic [7:0] REG_OFF [6] = '{bcm_pkg::OFF_C_MASK_HI, bcm_pkg::OFF_C_MASK_LO, bcm_pkg::OFF_C_CYCLE,
                                           bcm_pkg::OFF_C_COUNT, bcm_pkg::OFF_D_ADDR_HI, bcm_pkg::OFF_D_ADDR_LO};
    logic        clk, rst_b, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        busValid, cycIsDma, cycIsData, cycIsWrite, cycInShortRepeat, xValid, yValid;
    logic [31:0] busAddr, busData;
    logic [1:0]  cycSize;
    logic [15:0] xAddr, xData, yAddr, yData;
    logic        breakReq, chanCHit, chanDHit;
    int          failures, checks, cycles;

    bcm_match i_bcm_match (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .busValid(busValid), .busAddr(busAddr), .busData(busData), .cycIsDma(cycIsDma), .cycIsData(cycIsData),
        .cycIsWrite(cycIsWrite), .cycSize(cycSize), .cycInShortRepeat(cycInShortRepeat), .xValid(xValid),
        .xAddr(xAddr), .xData(xData), .yValid(yValid), .yAddr(yAddr), .yData(yData), .breakReq(breakReq),
        .chanCHit(chanCHit), .chanDHit(chanDHit));
    bcm_bus_model i_bcm_bus_model (.clk(clk), .busValid(busValid), .busAddr(busAddr), .busData(busData),
        .cycIsDma(cycIsDma), .cycIsData(cycIsData), .cycIsWrite(cycIsWrite), .cycSize(cycSize),
        .cycInShortRepeat(cycInShortRepeat), .xValid(xValid), .xAddr(xAddr), .xData(xData), .yValid(yValid),
        .yAddr(yAddr), .yData(yData));

    always #10 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            conclude();
        end
    end

    task automatic conclude();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : conclude

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    ////////////////////////////////////////////////////////////////////////////////
    task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, 16'h0000, d};
        @(posedge clk);
        penable <= 1'h1;
        @(posedge clk);
        while (pready !== 1'h1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'h0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        apb(1'h1, a, d);
    endtask : wr

    task automatic rdChk(input logic [7:0] a, input logic [15:0] exp);
        apb(1'h0, a, 16'h0000);
        check("register read", {16'h0000, exp}, rd);
    endtask : rdChk

    // outputs are registered: look one cycle after the bus cycle
    task automatic hit(input logic onXy, input logic ySel, input logic [31:0] a, input logic [31:0] d,
                       input logic [5:0] attr, input logic [2:0] exp);
        i_bcm_bus_model.cycle(onXy, ySel, a, d, attr);
        #1;
        check("break outputs", {29'h0, exp}, {29'h0, breakReq, chanCHit, chanDHit});
    endtask : hit

    ////////////////////////////////////////////////////////////////////////////////
    task automatic testReset();
        for (int i = 0; i < 6; i++) wr(REG_OFF[i], 16'h0A5A);
        @(posedge clk);
        rst_b <= 1'h0;
        repeat (2) @(posedge clk);
        rst_b <= 1'h1;
        for (int i = 0; i < 6; i++) rdChk(REG_OFF[i], 16'h0000);
        apb(1'h0, 8'h24, 16'h0000);
        check("unmapped error", 32'h1, {31'h0, err});
        $display("test reset done");
    endtask : testReset

    task automatic testReserved();
        wr(bcm_pkg::OFF_C_CYCLE, 16'hFFFF);
        rdChk(bcm_pkg::OFF_C_CYCLE, 16'h03FF);
        wr(bcm_pkg::OFF_C_COUNT, 16'hFFFF);
        rdChk(bcm_pkg::OFF_C_COUNT, 16'h0FFF);
        wr(bcm_pkg::OFF_C_MASK_HI, 16'hFFFF);
        rdChk(bcm_pkg::OFF_C_MASK_HI, 16'hFFFF);
        wr(bcm_pkg::OFF_C_COUNT, 16'h0000);
        $display("test reserved done");
    endtask : testReserved

    task automatic testByteMask();
        wr(bcm_pkg::OFF_C_CYCLE, 16'h0001);
        wr(bcm_pkg::OFF_C_DATA_LO, 16'h00A5);
        wr(bcm_pkg::OFF_C_MASK_LO, 16'hFF00);
        hit(1'h0, 1'h0, 32'h0010_1001, 32'h1234_56A5, 6'h12, 3'h6);
        hit(1'h0, 1'h0, 32'h0010_1001, 32'h1234_56A4, 6'h12, 3'h0);
        hit(1'h0, 1'h0, 32'h0010_1001, 32'h1234_56A5, 6'h14, 3'h0);
        $display("test byte mask done");
    endtask : testByteMask

    task automatic testAttributes();
        logic [15:0] cond;
        logic [5:0]  attr;
        logic        h;
        wr(bcm_pkg::OFF_C_MASK_LO, 16'hFFFF);
        for (int f = 0; f < 3; f++) for (int c = 1; c < 3; c++) for (int b = 0; b < 2; b++) begin
            cond = 16'(c) << (6 - 2 * f);
            attr = 6'h04 | (6'(b) << (5 - f));
            h = ((b == 1) == (c == 2));
            wr(bcm_pkg::OFF_C_CYCLE, cond);
            hit(1'h0, 1'h0, 32'h0010_1000, 32'h0, attr, {h, h, 1'h0});
        end
        $display("test attributes done");
    endtask : testAttributes

    task automatic testXy();
        wr(bcm_pkg::OFF_C_MASK_HI, 16'h0000);
        wr(bcm_pkg::OFF_C_MASK_LO, 16'h0000);
        wr(bcm_pkg::OFF_C_DATA_HI, 16'hBEEF);
        wr(bcm_pkg::OFF_C_DATA_LO, 16'h1234);
        wr(bcm_pkg::OFF_C_CYCLE, 16'h0200);
        hit(1'h1, 1'h0, 32'h0010_1000, 32'hBEEF_0000, 6'h14, 3'h6);
        hit(1'h1, 1'h0, 32'h0010_1000, 32'hBEEE_1234, 6'h14, 3'h0);
        hit(1'h0, 1'h0, 32'h0010_1000, 32'hBEEF_1234, 6'h14, 3'h0);
        wr(bcm_pkg::OFF_C_MASK_HI, 16'h0001);
        hit(1'h1, 1'h0, 32'h0010_1000, 32'hBEEE_0000, 6'h14, 3'h6);
        wr(bcm_pkg::OFF_C_CYCLE, 16'h0300);
        hit(1'h1, 1'h1, 32'h0010_1000, 32'h0000_1234, 6'h14, 3'h6);
        hit(1'h1, 1'h0, 32'h0010_1000, 32'hBEEF_1234, 6'h14, 3'h0);
        wr(bcm_pkg::OFF_C_CYCLE, 16'h0100);
        hit(1'h0, 1'h0, 32'h0010_1000, 32'hBEEF_1234, 6'h14, 3'h6);
        $display("test xy done");
    endtask : testXy

    task automatic testChanD();
        wr(bcm_pkg::OFF_D_ADDR_HI, 16'h0010);
        wr(bcm_pkg::OFF_D_ADDR_LO, 16'h2000);
        hit(1'h0, 1'h0, 32'h0010_2000, 32'h0, 6'h14, 3'h5);
        hit(1'h0, 1'h0, 32'h0010_2001, 32'h0, 6'h14, 3'h0);
        wr(bcm_pkg::OFF_CONTROL, 16'h0002);
        hit(1'h1, 1'h0, 32'h0011_0000, 32'h0, 6'h14, 3'h5);
        hit(1'h1, 1'h0, 32'h0012_0000, 32'h0, 6'h14, 3'h0);
        wr(bcm_pkg::OFF_CONTROL, 16'h0006);
        hit(1'h1, 1'h1, 32'h0000_2001, 32'h0, 6'h14, 3'h5);
        $display("test channel d done");
    endtask : testChanD

    task automatic testCount();
        wr(bcm_pkg::OFF_CONTROL, 16'h0001);
        wr(bcm_pkg::OFF_C_MASK_HI, 16'hFFFF);
        wr(bcm_pkg::OFF_C_MASK_LO, 16'hFFFF);
        wr(bcm_pkg::OFF_C_CYCLE, 16'h0000);
        wr(bcm_pkg::OFF_C_COUNT, 16'h0003);
        hit(1'h0, 1'h0, 32'h0010_1000, 32'h0, 6'h14, 3'h2);
        rdChk(bcm_pkg::OFF_C_COUNT, 16'h0002);
        hit(1'h0, 1'h0, 32'h0010_1000, 32'h0, 6'h15, 3'h2);
        rdChk(bcm_pkg::OFF_C_COUNT, 16'h0002);
        hit(1'h0, 1'h0, 32'h0010_1000, 32'h0, 6'h14, 3'h2);
        rdChk(bcm_pkg::OFF_C_COUNT, 16'h0001);
        hit(1'h0, 1'h0, 32'h0010_1000, 32'h0, 6'h14, 3'h6);
        rdChk(bcm_pkg::OFF_C_COUNT, 16'h0000);
        hit(1'h0, 1'h0, 32'h0010_1000, 32'h0, 6'h14, 3'h6);
        rdChk(bcm_pkg::OFF_C_COUNT, 16'h0000);
        $display("test count done");
    endtask : testCount

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {clk, rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
        {failures, checks, cycles} = '0;
        repeat (2) @(posedge clk);
        rst_b <= 1'h1;
        testReset();
        testReserved();
        testByteMask();
        testAttributes();
        testXy();
        testChanD();
        testCount();
        conclude();
    end
endmodule : bcm_match_test
